/* File: hdl/q_mem_if.sv */
`timescale 1ns/1ps
`default_nettype none
// Write and read port of one queue memory
interface q_mem_if #(parameter int W = 64, parameter int AW = 4);
  logic we;
  logic [AW-1:0] wa;
  logic [W-1:0] wd;
  logic [AW-1:0] ra;
  logic [W-1:0] rd;
  modport mem (input we, input wa, input wd, input ra, output rd);
  modport user (output we, output wa, output wd, output ra, input rd);
endinterface
`default_nettype wire

/* File: hdl/tlp_queue_mem.sv */
`timescale 1ns/1ps
`default_nettype none
// Queue storage; read data registered, so one cycle of latency
module tlp_queue_mem #(
  parameter int W = 64,
  parameter int DEPTH = 16
) (
  // Clock
  input wire logic clk_sys,
  // Port
  q_mem_if.mem port
);

  // Storage array, no reset needed
  logic [W-1:0] mem [DEPTH];

  // Write when enabled, registered read every cycle
  always_ff @(posedge clk_sys)
  begin
    if (port.we)
    begin
      mem[port.wa] <= port.wd;
    end
    port.rd <= mem[port.ra];
  end

endmodule
`default_nettype wire

/* File: hdl/tlp_route_pkg.sv */
package tlp_route_pkg;

  // Packet kinds seen on either stream
  typedef enum logic [3:0] {
    K_MRD, K_MWR, K_IORD, K_IOWR, config_read_type0, config_write_type0,
    K_CFGRD1, K_CFGWR1, K_CPL, K_CPLD, K_MSG_PM, K_MSG_SLOT,
    K_MSG_VENDOR, K_MSG_INT, K_MSG_ERR, K_OTHER
  } kind_t;

  // One packet descriptor, header summary plus one data word
  typedef struct packed {
    kind_t kind;
    logic fmt64;         // Header uses the 64-bit address format
    logic addr_hi_zero;  // Address lies below 4 GB
    logic bar_hit;       // Address matches a defined BAR
    logic relaxed;       // Relaxed ordering attribute
    logic [7:0] bus;     // Target bus number
    logic [15:0] req_id; // Requester or completer identity
    logic [31:0] data;
  } tlp_t;

  localparam int TLP_W = $bits(tlp_t);
  localparam int RXQ_DEPTH = 16;

  // Completion status words
  localparam logic [31:0] CPL_OK = 32'h0000_0000;
  localparam logic [31:0] CPL_UR = 32'h0000_0001;

  // Register offsets
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_SUBBUS = 4'h4;
  localparam logic [3:0] REG_STATUS = 4'h8;
  localparam logic [3:0] REG_MASK = 4'hC;

  // Control and status bit positions
  localparam int CTRL_ROOT = 0;
  localparam int CTRL_AER = 1;
  localparam int EV_UR = 0;
  localparam int EV_MAL = 1;
  localparam int EV_MSG = 2;
  localparam int EV_W = 3;
  localparam int BUS_W = 8;

endpackage

/* File: hdl/tlp_router.sv */
`timescale 1ns/1ps
`default_nettype none
// Routing and receive reordering for the transaction layer
module tlp_router #(
  parameter int DEPTH = tlp_route_pkg::RXQ_DEPTH
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic irq,
  // Received packets from the link
  input wire logic rx_valid,
  input wire tlp_route_pkg::tlp_t rx_tlp,
  output logic rx_ready,
  // Receive stream to the application
  output logic app_rx_valid,
  output tlp_route_pkg::tlp_t app_rx_tlp,
  input wire logic app_rx_ready,
  input wire logic rx_mask,
  // Transmit stream from the application
  input wire logic app_tx_valid,
  input wire tlp_route_pkg::tlp_t app_tx_tlp,
  output logic app_tx_ready,
  // Transmit stream to the link
  output logic link_tx_valid,
  output tlp_route_pkg::tlp_t link_tx_tlp,
  input wire logic link_tx_ready,
  // Internal configuration space
  output logic cfg_valid,
  output tlp_route_pkg::tlp_t cfg_tlp,
  input wire logic [31:0] cfg_rdata,
  // Dedicated message requests
  input wire logic pm_req,
  input wire logic int_req,
  input wire logic err_req,
  input wire logic msi_req,
  input wire logic [31:0] msi_data
);
  import tlp_route_pkg::*;

  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);
  localparam logic [AW:0] PTR_ONE = (AW+1)'(1);

  // Read sequencer states
  typedef enum logic {RD_IDLE, RD_FETCH} rd_t;

  // Whole state of the block except the two queue memories
  typedef struct packed {
    logic [AW:0] pc_wp;    // Posted and completion queue pointers
    logic [AW:0] pc_rp;
    logic [AW:0] np_wp;    // Non-posted queue pointers
    logic [AW:0] np_rp;
    rd_t rd;
    logic rd_np;           // Fetch in flight is from the np queue
    logic out_v;
    tlp_t out;
    logic lk_v;
    tlp_t lk;
    logic cf_v;
    tlp_t cf;
    logic cpl_p;           // Internal completion waiting
    tlp_t cpl;
    logic err_p;
    logic pm_p;
    logic int_p;
    logic msi_p;
    logic [31:0] msi_d;
    logic [EV_W-1:0] sts;
    logic [EV_W-1:0] msk;
    logic root;
    logic aer;
    logic [BUS_W-1:0] sub;
    logic [31:0] rdat;
  } st_t;

  st_t s_q, s_d;

  // Queue memory ports
  q_mem_if #(.W(TLP_W), .AW(AW)) pc_if();
  q_mem_if #(.W(TLP_W), .AW(AW)) np_if();

  // Receive route decisions
  logic go_pc, go_np, go_cfg, go_cons, go_ur, go_mal, need_cpl;
  logic pc_empty, np_empty, pc_full, np_full;
  logic any_int, lk_free;
  logic [EV_W-1:0] ev;
  tlp_t tx_conv;

  tlp_queue_mem #(.W(TLP_W), .DEPTH(DEPTH)) u_pc_mem (
    .clk_sys(clk_sys),
    .port(pc_if)
  );

  tlp_queue_mem #(.W(TLP_W), .DEPTH(DEPTH)) u_np_mem (
    .clk_sys(clk_sys),
    .port(np_if)
  );

  // Queue levels
  assign pc_empty = s_q.pc_wp == s_q.pc_rp;
  assign np_empty = s_q.np_wp == s_q.np_rp;
  assign pc_full = (s_q.pc_wp - s_q.pc_rp) == FULL_CNT;
  assign np_full = (s_q.np_wp - s_q.np_rp) == FULL_CNT;

  // Stall the link while a queue is full or a completion or error message is pending
  assign rx_ready = !pc_full && !np_full && !s_q.cpl_p && !s_q.err_p;

  // Classify a received packet
  always_comb
  begin
    go_pc = 1'b0;
    go_np = 1'b0;
    go_cfg = 1'b0;
    go_cons = 1'b0;
    go_ur = 1'b0;
    go_mal = 1'b0;
    need_cpl = rx_tlp.kind inside {K_MRD, K_IORD, K_IOWR,
      config_read_type0, config_write_type0, K_CFGRD1, K_CFGWR1};
    if (rx_tlp.kind inside {K_MRD, K_MWR} && rx_tlp.fmt64
        && rx_tlp.addr_hi_zero)
    begin
      go_mal = 1'b1;
    end
    else if (rx_tlp.kind inside {K_MRD, K_IORD, K_IOWR}
             && rx_tlp.bar_hit)
    begin
      go_np = 1'b1;
    end
    else if ((rx_tlp.kind == K_MWR && rx_tlp.bar_hit)
             || rx_tlp.kind == K_MSG_VENDOR)
    begin
      go_pc = 1'b1;
    end
    else if (rx_tlp.kind inside {K_CPL, K_CPLD})
    begin
      go_pc = 1'b1;
    end
    else if (rx_tlp.kind inside {config_read_type0, config_write_type0}
             && !s_q.root)
    begin
      go_cfg = 1'b1;
    end
    else if (rx_tlp.kind inside {K_MSG_PM, K_MSG_SLOT})
    begin
      go_cons = 1'b1;
    end
    else
    begin
      go_ur = 1'b1;
    end
  end

  // Queue writes, one shared data word for both memories
  assign pc_if.we = rx_valid && rx_ready && go_pc;
  assign np_if.we = rx_valid && rx_ready && go_np;
  assign pc_if.wa = s_q.pc_wp[AW-1:0];
  assign np_if.wa = s_q.np_wp[AW-1:0];
  assign pc_if.wd = rx_tlp;
  assign np_if.wd = rx_tlp;
  // Reads always point at the queue heads
  assign pc_if.ra = s_q.pc_rp[AW-1:0];
  assign np_if.ra = s_q.np_rp[AW-1:0];

  // Events from this cycle's received packet
  assign ev[EV_UR] = rx_valid && rx_ready && go_ur;
  assign ev[EV_MAL] = rx_valid && rx_ready && go_mal;
  assign ev[EV_MSG] = rx_valid && rx_ready && go_cons;

  // Link slot free, internal traffic waiting
  assign lk_free = !s_q.lk_v || link_tx_ready;
  assign any_int = s_q.cpl_p || s_q.err_p || s_q.pm_p || s_q.int_p
    || s_q.msi_p;
  assign app_tx_ready = lk_free && !any_int;

  // Root port rewrite of type 1 on the last bus
  always_comb
  begin
    tx_conv = app_tx_tlp;
    if (s_q.root && app_tx_tlp.bus == s_q.sub)
    begin
      if (app_tx_tlp.kind == K_CFGRD1)
      begin
        tx_conv.kind = config_read_type0;
      end
      else if (app_tx_tlp.kind == K_CFGWR1)
      begin
        tx_conv.kind = config_write_type0;
      end
    end
  end

  // Next state
  always_comb
  begin
    s_d = s_q;
    s_d.cf_v = 1'b0;
    s_d.rdat = '0;
    // Register writes
    if (reg_wr)
    begin
      unique case (reg_addr)
        REG_CTRL:
        begin
          s_d.root = reg_wdata[CTRL_ROOT];
          s_d.aer = reg_wdata[CTRL_AER];
        end
        REG_SUBBUS: s_d.sub = reg_wdata[BUS_W-1:0];
        REG_MASK: s_d.msk = reg_wdata[EV_W-1:0];
        default: ;
      endcase
    end
    // Register reads; status clears when read
    if (reg_rd)
    begin
      unique case (reg_addr)
        REG_CTRL:
        begin
          s_d.rdat[CTRL_ROOT] = s_q.root;
          s_d.rdat[CTRL_AER] = s_q.aer;
        end
        REG_SUBBUS: s_d.rdat[BUS_W-1:0] = s_q.sub;
        REG_STATUS:
        begin
          s_d.rdat[EV_W-1:0] = s_q.sts;
          s_d.sts = '0;
        end
        REG_MASK: s_d.rdat[EV_W-1:0] = s_q.msk;
        default: ;
      endcase
    end
    // Set after clear, so an event in the read cycle survives
    s_d.sts = s_d.sts | ev;
    // Application took the presented packet
    if (s_q.out_v && app_rx_ready)
    begin
      s_d.out_v = 1'b0;
    end
    // Head fetch; posted and completions first, FIFO keeps order
    unique case (s_q.rd)
      RD_IDLE:
      begin
        if (!s_q.out_v && !pc_empty)
        begin
          s_d.pc_rp = s_q.pc_rp + PTR_ONE;
          s_d.rd_np = 1'b0;
          s_d.rd = RD_FETCH;
        end
        else if (!s_q.out_v && !np_empty && !rx_mask)
        begin
          s_d.np_rp = s_q.np_rp + PTR_ONE;
          s_d.rd_np = 1'b1;
          s_d.rd = RD_FETCH;
        end
      end
      RD_FETCH:
      begin
        s_d.out = s_q.rd_np ? tlp_t'(np_if.rd) : tlp_t'(pc_if.rd);
        s_d.out_v = 1'b1;
        s_d.rd = RD_IDLE;
      end
    endcase
    // Receive side effects
    if (pc_if.we)
    begin
      s_d.pc_wp = s_q.pc_wp + PTR_ONE;
    end
    if (np_if.we)
    begin
      s_d.np_wp = s_q.np_wp + PTR_ONE;
    end
    if (rx_valid && rx_ready)
    begin
      // Config skips the np queue, so it overtakes memory and IO
      if (go_cfg)
      begin
        s_d.cf_v = 1'b1;
        s_d.cf = rx_tlp;
        s_d.cpl_p = 1'b1;
        s_d.cpl = '0;
        s_d.cpl.kind = rx_tlp.kind == config_read_type0 ? K_CPLD : K_CPL;
        s_d.cpl.req_id = rx_tlp.req_id;
        s_d.cpl.data = CPL_OK;
      end
      // Unsupported: header and data dropped, reply if owed
      if (go_ur && need_cpl)
      begin
        s_d.cpl_p = 1'b1;
        s_d.cpl = '0;
        s_d.cpl.kind = K_CPL;
        s_d.cpl.req_id = rx_tlp.req_id;
        s_d.cpl.data = CPL_UR;
      end
      if (go_mal && s_q.aer)
      begin
        s_d.err_p = 1'b1;
      end
    end
    // Link transmit; internal replies ahead of the application
    if (s_q.lk_v && link_tx_ready)
    begin
      s_d.lk_v = 1'b0;
    end
    if (lk_free)
    begin
      s_d.lk = '0;
      if (s_q.cpl_p)
      begin
        s_d.lk_v = 1'b1;
        s_d.lk = s_q.cpl;
        if (s_q.cpl.kind == K_CPLD)
        begin
          s_d.lk.data = cfg_rdata;
        end
        s_d.cpl_p = 1'b0;
      end
      else if (s_q.err_p)
      begin
        s_d.lk_v = 1'b1;
        s_d.lk.kind = K_MSG_ERR;
        s_d.err_p = 1'b0;
      end
      else if (s_q.pm_p)
      begin
        s_d.lk_v = 1'b1;
        s_d.lk.kind = K_MSG_PM;
        s_d.pm_p = 1'b0;
      end
      else if (s_q.int_p)
      begin
        s_d.lk_v = 1'b1;
        s_d.lk.kind = K_MSG_INT;
        s_d.int_p = 1'b0;
      end
      else if (s_q.msi_p)
      begin
        // Same kind as any memory write, but sent ahead of any waiting application packet
        s_d.lk_v = 1'b1;
        s_d.lk.kind = K_MWR;
        s_d.lk.data = s_q.msi_d;
        s_d.msi_p = 1'b0;
      end
      else if (app_tx_valid)
      begin
        if (s_q.root && app_tx_tlp.kind inside {config_read_type0,
            config_write_type0})
        begin
          s_d.cf_v = 1'b1;
          s_d.cf = app_tx_tlp;
        end
        else
        begin
          s_d.lk_v = 1'b1;
          s_d.lk = tx_conv;
        end
      end
    end
    // Dedicated requests latch after the clears, so set wins
    if (pm_req)
    begin
      s_d.pm_p = 1'b1;
    end
    if (int_req)
    begin
      s_d.int_p = 1'b1;
    end
    if (err_req)
    begin
      s_d.err_p = 1'b1;
    end
    if (msi_req)
    begin
      s_d.msi_p = 1'b1;
      s_d.msi_d = msi_data;
    end
  end

  // State register
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // Outputs
  assign reg_rdata = s_q.rdat;
  assign irq = |(s_q.sts & s_q.msk);
  assign app_rx_valid = s_q.out_v;
  assign app_rx_tlp = s_q.out;
  assign link_tx_valid = s_q.lk_v;
  assign link_tx_tlp = s_q.lk;
  assign cfg_valid = s_q.cf_v;
  assign cfg_tlp = s_q.cf;

endmodule
`default_nettype wire

/* File: verification/tlp_app_model.sv */
`timescale 1ns/1ps
`default_nettype none
// Application and link sink; records what it takes
module tlp_app_model (
  // Clock
  input wire logic clk_sys,
  // Streams
  input wire logic app_rx_valid,
  input wire tlp_route_pkg::tlp_t app_rx_tlp,
  output logic app_rx_ready,
  input wire logic link_tx_valid,
  input wire tlp_route_pkg::tlp_t link_tx_tlp,
  output logic link_tx_ready,
  output logic [31:0] cfg_rdata,
  // Slow mode
  input wire logic stall
);
  import tlp_route_pkg::*;
  tlp_t rxq[$];  // Taken by the application
  tlp_t lq[$];   // Taken by the link
  assign cfg_rdata = 32'hC0DE_0042;
  assign app_rx_ready = !stall;
  // Link ready toggles while slow, so holds are exercised
  always @(posedge clk_sys)
  begin
    link_tx_ready <= !stall || !link_tx_ready;
    if (app_rx_valid && app_rx_ready)
      rxq.push_back(app_rx_tlp);
    if (link_tx_valid && link_tx_ready)
      lq.push_back(link_tx_tlp);
  end
endmodule
`default_nettype wire

/* File: verification/tlp_router_sva.sv */
`timescale 1ns/1ps
`default_nettype none
// Port-level checks on the router
module tlp_router_sva (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Streams
  input wire logic rx_mask,
  input wire logic app_rx_valid,
  input wire tlp_route_pkg::tlp_t app_rx_tlp,
  input wire logic app_rx_ready,
  input wire logic app_tx_valid,
  input wire tlp_route_pkg::tlp_t app_tx_tlp,
  input wire logic app_tx_ready,
  input wire logic link_tx_valid,
  input wire tlp_route_pkg::tlp_t link_tx_tlp,
  input wire logic link_tx_ready
);
  import tlp_route_pkg::*;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  // Kind shown to the application
  kind_t k;
  assign k = app_rx_tlp.kind;
  AST_RX_HOLD: assert property (
    app_rx_valid && !app_rx_ready |=> app_rx_valid && $stable(app_rx_tlp))
    else $error("rx offer dropped");
  AST_TX_HOLD: assert property (
    link_tx_valid && !link_tx_ready |=> link_tx_valid && $stable(link_tx_tlp))
    else $error("link offer dropped");
  AST_TX_PASS: assert property (
    app_tx_valid && app_tx_ready && app_tx_tlp.kind == K_MWR |=>
    link_tx_valid && link_tx_tlp == $past(app_tx_tlp))
    else $error("write not on link");
  // Mask settled for three cycles, so no non-posted may appear
  AST_MASK_NP: assert property (
    rx_mask[*3] ##0 $rose(app_rx_valid) |->
    !(k inside {K_MRD, K_IORD, K_IOWR}))
    else $error("non-posted passed mask");
  AST_NO_MAL: assert property (app_rx_valid |->
    !(k inside {K_MRD, K_MWR} && app_rx_tlp.fmt64 && app_rx_tlp.addr_hi_zero))
    else $error("malformed shown");
  AST_NO_PM: assert property (
    app_rx_valid |-> !(k inside {K_MSG_PM, K_MSG_SLOT}))
    else $error("power message shown");
  AST_NO_UR: assert property (
    app_rx_valid && k inside {K_MRD, K_MWR, K_IORD, K_IOWR} |->
    app_rx_tlp.bar_hit)
    else $error("miss shown");
  AST_NO_CFG0: assert property (
    app_rx_valid |-> !(k inside {config_read_type0, config_write_type0}))
    else $error("config shown");
  // Main scenarios reached
  cover property (rx_mask && $rose(app_rx_valid));
  cover property (link_tx_valid && link_tx_tlp.kind == config_read_type0);
  cover property (app_rx_valid && !app_rx_ready ##1 app_rx_valid);
endmodule
bind tlp_router tlp_router_sva tlp_router_sva_inst (.*);
`default_nettype wire

/* File: verification/tlp_router_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tlp_router_tb;
  import tlp_route_pkg::*;
  logic clk_sys = 0, sys_rst = 1, reg_wr = 0, reg_rd = 0, irq, rx_valid = 0;
  logic rx_ready, app_rx_valid, app_rx_ready, rx_mask = 0, cfg_valid;
  logic app_tx_valid = 0, app_tx_ready, link_tx_valid, link_tx_ready;
  logic pm_req = 0, int_req = 0, err_req = 0, msi_req = 0, stall = 0;
  logic [3:0] reg_addr = '0;
  logic [31:0] reg_wdata = '0, reg_rdata, msi_data = '0, cfg_rdata;
  tlp_t rx_tlp = '0, app_tx_tlp = '0, app_rx_tlp, link_tx_tlp, cfg_tlp, m;
  int failures = 0, total_checks = 0;
  int cfg_cnt = 0;        // Pulses seen on the config space port
  tlp_t cfg_last = '0;    // Last packet handed to the config space
  tlp_router #(.DEPTH(4)) tlp_router_inst (.*);
  tlp_app_model tlp_app_model_inst (.*);
  // Config space traffic seen by the bench
  always @(posedge clk_sys)
  begin
    if (cfg_valid === 1'b1)
    begin
      cfg_cnt <= cfg_cnt + 1;
      cfg_last <= cfg_tlp;
    end
  end
  initial forever #25 clk_sys = !clk_sys;
  task automatic tally_and_finish;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // Compare and count
  task automatic chk(input logic [63:0] s, e, input string n);
    total_checks++;
    if (s !== e)
    begin
      failures++;
      $display("ERROR %s exp %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1;
    @(posedge clk_sys);
    reg_wr <= 0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, input logic [31:0] e, input string n);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1;
    @(posedge clk_sys);
    reg_rd <= 0;
    #1 chk(reg_rdata, e, n);
  endtask
  // Offer on link receive or application transmit, held until taken
  task automatic send(input tlp_t t, input bit tx);
    int i;
    @(posedge clk_sys);
    app_tx_valid <= tx;
    rx_valid <= !tx;
    rx_tlp <= t;
    app_tx_tlp <= t;
    for (i = 0; i < 200; i++)
    begin
      @(posedge clk_sys);
      if ((tx ? app_tx_ready : rx_ready) === 1'b1)
        break;
    end
    // A packet never taken counts as a mismatch
    chk(i < 200, 1, "send taken");
    app_tx_valid <= 0;
    rx_valid <= 0;
  endtask
  // Bounded wait for a queue of the sink to fill
  task automatic waitq(input int n, input bit lnk);
    int i;
    for (i = 0; i < 100; i++)
    begin
      @(posedge clk_sys);
      if ((lnk ? tlp_app_model_inst.lq.size() :
          tlp_app_model_inst.rxq.size()) >= n)
        break;
    end
    // A queue that never fills counts as a mismatch
    chk(i < 100, 1, "queue filled");
  endtask
  // Descriptor below 4 GB in 32-bit form; bus copies data
  function automatic tlp_t mk(kind_t k, logic b, logic [31:0] d);
    tlp_t t;
    t = '0;
    t.kind = k;
    t.bar_hit = b;
    t.addr_hi_zero = 1'b1;
    t.bus = d[7:0];
    t.data = d;
    return t;
  endfunction
  // Hang guard at 4000 clock cycles, over ten times the expected run
  initial
  begin
    #200000;
    failures++;
    tally_and_finish();
  end
  initial
  begin
    repeat (2) @(posedge clk_sys);
    sys_rst <= 0;
    rd(REG_CTRL, '0, "ctrl");
    rd(REG_MASK, '0, "mask");
    wr(REG_SUBBUS, 32'h0000_0105);
    rd(REG_SUBBUS, 8'h05, "subbus");
    wr(4'h2, 32'hFFFF_FFFF);
    rd(4'h2, '0, "unmapped");
    $display("test registers done");
    send(mk(K_MRD, 0, 8'h02), 0);
    send(mk(K_MWR, 1, 8'h01), 0);
    send(mk(K_MSG_PM, 0, 8'h03), 0);
    m = mk(K_MWR, 1, 8'h04);
    m.fmt64 = 1;
    send(m, 0);
    send(mk(K_MSG_VENDOR, 0, 8'h05), 0);
    waitq(2, 0);
    waitq(1, 1);
    chk(irq, 0, "irq masked");
    wr(REG_MASK, 8'h07);
    rd(REG_MASK, 8'h07, "mask");
    chk(irq, 1, "irq");
    rd(REG_STATUS, 8'h07, "status");
    rd(REG_STATUS, '0, "status clear");
    chk(irq, 0, "irq clear");
    chk(tlp_app_model_inst.rxq[0].data, 8'h01, "mwr");
    chk(tlp_app_model_inst.rxq[1].data, 8'h05, "vendor");
    chk(tlp_app_model_inst.lq[0].data, CPL_UR, "ur cpl");
    $display("test routing done");
    stall <= 1;
    rx_mask <= 1;
    send(mk(K_MRD, 1, 8'h10), 0);
    send(mk(K_MWR, 1, 8'h11), 0);
    send(mk(K_MWR, 1, 8'h12), 0);
    send(mk(K_CPLD, 0, 8'h13), 0);
    send(mk(K_CPLD, 0, 8'h15), 0);
    send(mk(config_read_type0, 0, 8'h14), 0);
    waitq(2, 1);
    chk(tlp_app_model_inst.lq[1].data, 32'hC0DE_0042, "cfg cpl");
    chk(cfg_cnt, 1, "cfg count");
    chk(cfg_last.data, 8'h14, "cfg tlp");
    stall <= 0;
    waitq(6, 0);
    // Room for a wrongly released non-posted request to show up
    repeat (20) @(posedge clk_sys);
    chk(tlp_app_model_inst.rxq[2].data, 8'h11, "posted 1");
    chk(tlp_app_model_inst.rxq[3].data, 8'h12, "posted 2");
    chk(tlp_app_model_inst.rxq[4].data, 8'h13, "cpl");
    chk(tlp_app_model_inst.rxq[5].data, 8'h15, "cpl order");
    chk(tlp_app_model_inst.rxq.size(), 6, "held");
    rx_mask <= 0;
    waitq(7, 0);
    chk(tlp_app_model_inst.rxq[6].data, 8'h10, "resumed");
    $display("test reorder done");
    send(mk(K_MWR, 0, 8'h20), 1);
    wr(REG_CTRL, 8'h01);
    send(mk(K_CFGRD1, 0, 8'h05), 1);
    send(mk(K_CFGRD1, 0, 8'h06), 1);
    send(mk(config_write_type0, 0, 8'h07), 1);
    @(posedge clk_sys);
    {pm_req, int_req, err_req, msi_req} <= 4'hF;
    msi_data <= 8'h77;
    @(posedge clk_sys);
    {pm_req, int_req, err_req, msi_req} <= 4'h0;
    waitq(9, 1);
    chk(tlp_app_model_inst.lq[2].data, 8'h20, "tx mwr");
    chk(tlp_app_model_inst.lq[3].kind, config_read_type0, "rewrite");
    chk(tlp_app_model_inst.lq[4].kind, K_CFGRD1, "type1");
    chk(tlp_app_model_inst.lq[5].kind, K_MSG_ERR, "err msg");
    chk(tlp_app_model_inst.lq.size(), 9, "link count");
    chk(cfg_cnt, 2, "root cfg count");
    chk(cfg_last.kind, config_write_type0, "root cfg");
    chk(cfg_last.data, 8'h07, "root cfg data");
    chk(tlp_app_model_inst.lq[6].kind, K_MSG_PM, "pm msg");
    chk(tlp_app_model_inst.lq[7].kind, K_MSG_INT, "int msg");
    chk(tlp_app_model_inst.lq[8].kind, K_MWR, "msi kind");
    chk(tlp_app_model_inst.lq[8].data, 8'h77, "msi data");
    $display("test transmit done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
